// ===== rtl/mfs_top.sv
// Measurement fault sequencer with APB register slave
`timescale 1ns/1ps
module mfs_top #(
  parameter int unsigned SHORT_DELAY_CYC = mfs_pkg::SHORT_DELAY_MS * mfs_pkg::MS_CYCLES,
  parameter int unsigned MS_CYC = mfs_pkg::MS_CYCLES,
  parameter int unsigned CHECK_CYC = mfs_pkg::CHECK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Handler I/O
  input wire logic measure_start_in,
  input wire logic short_check_request_n,
  output logic measure_done_out,
  output logic probe_short_flag_n,
  output logic error_out,
  output logic settings_alarm,
  // Analog front end
  output logic meas_go,
  output logic check_go,
  input wire logic meas_end,
  input wire logic meas_fault,
  input wire logic check_end,
  input wire logic [15:0] probe_ohms,
  // Peer link words
  input wire logic peer_valid,
  input wire logic peer_enabled,
  input wire logic peer_second,
  input wire logic [7:0] peer_speed,
  input wire logic [15:0] peer_upper,
  input wire logic [15:0] peer_lower
);
  typedef struct packed {
    mfs_pkg::mfs_state_t st;
    logic [31:0] cnt;
    logic [31:0] retry_cnt;
    logic check_pend;
    logic [4:0] ctrl;
    logic [13:0] tol;
    logic [5:0] retry_ms;
    logic [15:0] short_ms;
    logic [7:0] speed;
    logic [15:0] upper;
    logic [15:0] lower;
    logic match;
    logic alarm;
    logic done;
    logic short_flag;
    logic err;
    logic [7:0] err_code;
    logic go;
    logic cgo;
    logic [31:0] rdata;
  } mfs_reg_t;

  mfs_reg_t q, d;
  logic wr, rd;

  function automatic logic cmp_ok(input logic [7:0] sp, input logic [15:0] up, input logic [15:0] lo,
                                  input logic [7:0] psp, input logic [15:0] pup, input logic [15:0] plo,
                                  input logic second, input logic psecond);
    logic nest;
    nest = 1'b0;
    // Second stage window may enclose the first
    if (second) begin
      nest = (pup <= up) && (plo >= lo);
    end else if (psecond) begin
      nest = (up <= pup) && (lo >= plo);
    end
    cmp_ok = (sp == psp) && (((up == pup) && (lo == plo)) || nest);
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  always_comb begin
    d = q;
    d.go = 1'b0;
    d.cgo = 1'b0;
    d.done = 1'b0;
    // Register writes
    if (wr) begin
      if (paddr == mfs_pkg::ADDR_CTRL) begin
        d.ctrl = pwdata[4:0];
      end else if (paddr == mfs_pkg::ADDR_TIMING) begin
        if (pwdata[5:0] >= 6'(mfs_pkg::RETRY_MIN_MS) && pwdata[5:0] <= 6'(mfs_pkg::RETRY_MAX_MS)) begin
          d.retry_ms = pwdata[5:0];
        end
        if (pwdata[31:16] != 16'h0000) begin
          d.short_ms = pwdata[31:16];
        end
        if (pwdata[15:8] == 8'hA5) begin
          d.err_code = mfs_pkg::ERR_NONE;
          d.short_flag = 1'b0;
          d.err = 1'b0;
        end
      end else if (paddr == mfs_pkg::ADDR_LOCAL) begin
        d.speed = pwdata[7:0];
        d.upper = pwdata[23:8];
        if (pwdata[31:24] != 8'h00) begin
          d.lower = {8'h00, pwdata[31:24]};
        end
        if (pwdata[31:24] == 8'h00 && pwdata[13:0] <= 14'(mfs_pkg::TOL_MAX)) begin
          d.tol = pwdata[13:0];
        end
      end
    end
    // Comparison refreshed on each cycle with peer_valid high from the peer words
    if (!q.ctrl[mfs_pkg::CTRL_CMP_EN] || !peer_enabled) begin
      d.match = 1'b1;
    end else if (peer_valid) begin
      d.match = cmp_ok(q.speed, q.upper, q.lower, peer_speed, peer_upper, peer_lower,
                       q.ctrl[mfs_pkg::CTRL_SECOND], peer_second);
    end
    d.alarm = !d.match;
    // Requests seen during measurement are held for after it
    if (!short_check_request_n) begin
      d.check_pend = 1'b1;
    end
    case (q.st)
      mfs_pkg::MFS_IDLE: begin
        if (measure_start_in && q.match && d.match) begin
          d.st = mfs_pkg::MFS_MEAS;
          d.go = 1'b1;
          d.retry_cnt = 32'(q.retry_ms) * 32'(MS_CYC);
        end else if (q.check_pend) begin
          d.st = mfs_pkg::MFS_CHECK;
          d.cgo = 1'b1;
          d.check_pend = 1'b0;
          d.cnt = 32'(CHECK_CYC);
        end
      end
      mfs_pkg::MFS_MEAS: begin
        if (q.retry_cnt != 32'h0000_0000) begin
          d.retry_cnt = q.retry_cnt - 32'h0000_0001;
        end
        if (meas_fault) begin
          d.err = 1'b1;
          d.err_code = mfs_pkg::ERR_VOLT;
          if (q.ctrl[mfs_pkg::CTRL_RETRY_EN] && q.retry_cnt != 32'h0000_0000) begin
            d.go = 1'b1;
          end else begin
            d.st = mfs_pkg::MFS_POST;
            d.done = 1'b1;
          end
        end else if (meas_end) begin
          d.st = mfs_pkg::MFS_POST;
          d.done = 1'b1;
        end
      end
      mfs_pkg::MFS_POST: begin
        if (q.check_pend || !short_check_request_n) begin
          d.st = mfs_pkg::MFS_CHECK;
          d.cgo = 1'b1;
          d.check_pend = 1'b0;
          d.cnt = 32'(CHECK_CYC);
        end else if (q.ctrl[mfs_pkg::CTRL_SHORT_EN] && !q.ctrl[mfs_pkg::CTRL_INT_TRIGGER]) begin
          d.st = mfs_pkg::MFS_WAIT;
          d.cnt = (q.short_ms == 16'(mfs_pkg::SHORT_DELAY_MS)) ? 32'(SHORT_DELAY_CYC)
                  : 32'(q.short_ms) * 32'(MS_CYC);
        end else begin
          d.st = mfs_pkg::MFS_IDLE;
        end
      end
      mfs_pkg::MFS_WAIT: begin
        if (q.cnt <= 32'h0000_0001) begin
          d.st = mfs_pkg::MFS_CHECK;
          d.cgo = 1'b1;
          d.check_pend = 1'b0;
          d.cnt = 32'(CHECK_CYC);
        end else begin
          d.cnt = q.cnt - 32'h0000_0001;
        end
      end
      mfs_pkg::MFS_CHECK: begin
        // Bounded wait keeps a dead front end from hanging
        if (check_end || q.cnt <= 32'h0000_0001) begin
          d.st = mfs_pkg::MFS_IDLE;
          if (check_end && probe_ohms < 16'(mfs_pkg::SHORT_OHMS)) begin
            d.short_flag = 1'b1;
            d.err = 1'b1;
            d.err_code = mfs_pkg::ERR_PROBE_SHORT;
          end
        end else begin
          d.cnt = q.cnt - 32'h0000_0001;
        end
      end
      default: begin
        d.st = mfs_pkg::MFS_IDLE;
      end
    endcase
    // Read data captured in setup phase
    if (rd) begin
      if (paddr == mfs_pkg::ADDR_CTRL) begin
        d.rdata = {27'h0, q.ctrl};
      end else if (paddr == mfs_pkg::ADDR_TIMING) begin
        d.rdata = {q.short_ms, 10'h0, q.retry_ms};
      end else if (paddr == mfs_pkg::ADDR_LOCAL) begin
        d.rdata = {q.lower[7:0], q.upper, q.speed};
      end else if (paddr == mfs_pkg::ADDR_STATUS) begin
        d.rdata = {18'h0, q.tol[7:0], q.match, q.alarm, q.short_flag, q.err, q.st[1:0]};
      end else if (paddr == mfs_pkg::ADDR_ERRCODE) begin
        d.rdata = {24'h0, q.err_code};
      end else begin
        d.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ctrl <= mfs_pkg::CTRL_RESET[4:0];
      q.retry_ms <= 6'(mfs_pkg::RETRY_DEF_MS);
      q.short_ms <= 16'(mfs_pkg::SHORT_DELAY_MS);
      q.match <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign pready = 1'b1;
  assign prdata = q.rdata;
  assign pslverr = psel && penable && !((paddr == mfs_pkg::ADDR_CTRL) || (paddr == mfs_pkg::ADDR_TIMING) ||
                   (paddr == mfs_pkg::ADDR_LOCAL) || (paddr == mfs_pkg::ADDR_STATUS) ||
                   (paddr == mfs_pkg::ADDR_ERRCODE));
  assign measure_done_out = q.done;
  assign probe_short_flag_n = !q.short_flag;
  assign error_out = q.err;
  assign settings_alarm = q.alarm;
  assign meas_go = q.go;
  assign check_go = q.cgo;

  property p_start;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_IDLE && measure_start_in && q.match && d.match) |=> meas_go;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_block;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_IDLE && q.alarm) |=> !meas_go;
  endproperty
  a_block: assert property (p_block) else $error("trigger not blocked");
  property p_short;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_CHECK && check_end && probe_ohms < 16'(mfs_pkg::SHORT_OHMS)) |=>
      (!probe_short_flag_n && error_out);
  endproperty
  a_short: assert property (p_short) else $error("short not flagged");
  property p_pass;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_CHECK && check_end && !q.short_flag && probe_ohms >= 16'(mfs_pkg::SHORT_OHMS))
      |=> probe_short_flag_n;
  endproperty
  a_pass: assert property (p_pass) else $error("false short");
  property p_req;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_POST && !short_check_request_n) |=> check_go;
  endproperty
  a_req: assert property (p_req) else $error("requested check missing");
  property p_int;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_POST && q.ctrl[mfs_pkg::CTRL_INT_TRIGGER] && !q.check_pend && short_check_request_n)
      |=> q.st == mfs_pkg::MFS_IDLE;
  endproperty
  a_int: assert property (p_int) else $error("auto check under internal trigger");
  property p_retry;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_MEAS && meas_fault && q.ctrl[mfs_pkg::CTRL_RETRY_EN] && q.retry_cnt != 32'h0000_0000)
      |=> (meas_go && !measure_done_out);
  endproperty
  a_retry: assert property (p_retry) else $error("no retry");
  sequence s_done_pulse;
    measure_done_out ##1 !measure_done_out;
  endsequence
  sequence s_check_launch;
    (check_go && q.st == mfs_pkg::MFS_CHECK) ##1 !check_go;
  endsequence
  property p_giveup;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_MEAS && meas_fault && q.retry_cnt == 32'h0000_0000) |=> s_done_pulse;
  endproperty
  a_giveup: assert property (p_giveup) else $error("retry not ended");
  property p_end;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_MEAS && meas_end && !meas_fault) |=> s_done_pulse;
  endproperty
  a_end: assert property (p_end) else $error("end of measurement not signalled");
  property p_fault_err;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_MEAS && meas_fault) |=> (error_out && q.err_code == mfs_pkg::ERR_VOLT);
  endproperty
  a_fault_err: assert property (p_fault_err) else $error("voltage fault not reported");
  property p_no_retry;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_MEAS && meas_fault && !q.ctrl[mfs_pkg::CTRL_RETRY_EN])
      |=> (measure_done_out && !meas_go);
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("retry while disabled");
  property p_wait_go;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_WAIT && q.cnt <= 32'h0000_0001) |=> s_check_launch;
  endproperty
  a_wait_go: assert property (p_wait_go) else $error("delayed check not launched");
  property p_auto;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_POST && q.ctrl[mfs_pkg::CTRL_SHORT_EN] && !q.ctrl[mfs_pkg::CTRL_INT_TRIGGER] &&
       !q.check_pend && short_check_request_n) |=> (q.st == mfs_pkg::MFS_WAIT && !check_go);
  endproperty
  a_auto: assert property (p_auto) else $error("auto check delay skipped");
  property p_auto_off;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_POST && !q.ctrl[mfs_pkg::CTRL_SHORT_EN] && !q.check_pend && short_check_request_n)
      |=> q.st == mfs_pkg::MFS_IDLE;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("check without request or setting");
  property p_idle_req;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_IDLE && !measure_start_in && q.check_pend) |=> s_check_launch;
  endproperty
  a_idle_req: assert property (p_idle_req) else $error("idle request not checked");
  property p_check_bound;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_CHECK && q.cnt <= 32'h0000_0001) |=> q.st == mfs_pkg::MFS_IDLE;
  endproperty
  a_check_bound: assert property (p_check_bound) else $error("check overran its time");
  property p_busy;
    @(posedge pclk) disable iff (!presetn)
      (q.st == mfs_pkg::MFS_POST || q.st == mfs_pkg::MFS_WAIT || q.st == mfs_pkg::MFS_CHECK) |=> !meas_go;
  endproperty
  a_busy: assert property (p_busy) else $error("start while busy");
  property p_retry_range;
    @(posedge pclk) disable iff (!presetn)
      (q.retry_ms >= 6'(mfs_pkg::RETRY_MIN_MS) && q.retry_ms <= 6'(mfs_pkg::RETRY_MAX_MS));
  endproperty
  a_retry_range: assert property (p_retry_range) else $error("retry interval out of range");
  property p_tol_range;
    @(posedge pclk) disable iff (!presetn)
      (q.tol <= 14'(mfs_pkg::TOL_MAX));
  endproperty
  a_tol_range: assert property (p_tol_range) else $error("tolerance out of range");
  property p_cmp_off;
    @(posedge pclk) disable iff (!presetn)
      (!q.ctrl[mfs_pkg::CTRL_CMP_EN] || !peer_enabled) |=> !settings_alarm;
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("alarm with comparison off");
  property p_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
      (!probe_short_flag_n && !(wr && paddr == mfs_pkg::ADDR_TIMING && pwdata[15:8] == 8'hA5))
      |=> !probe_short_flag_n;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("short flag lost");
  property p_err_sticky;
    @(posedge pclk) disable iff (!presetn)
      (error_out && !(wr && paddr == mfs_pkg::ADDR_TIMING && pwdata[15:8] == 8'hA5))
      |=> error_out;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error output lost");
  property p_alarm;
    @(posedge pclk) disable iff (!presetn)
      (q.ctrl[mfs_pkg::CTRL_CMP_EN] && peer_enabled && peer_valid && peer_speed != q.speed)
      |=> settings_alarm;
  endproperty
  a_alarm: assert property (p_alarm) else $error("speed mismatch not alarmed");
  property p_match_eq;
    @(posedge pclk) disable iff (!presetn)
      (q.ctrl[mfs_pkg::CTRL_CMP_EN] && peer_enabled && peer_valid && peer_speed == q.speed &&
       peer_upper == q.upper && peer_lower == q.lower) |=> !settings_alarm;
  endproperty
  a_match_eq: assert property (p_match_eq) else $error("equal settings alarmed");
endmodule

// ===== rtl/mfs_pkg.sv
// Constants and types for the measurement fault sequencer
// Overview of operation
// - With auto check on, short check runs a set delay after measurement, default 5 ms.
// - Auto short check setting is off after reset.
// - A found short posts an error code, drives short flag low and error output.
// - Check request low during a measurement runs the check after it ends.
// - The short check finishes within about one millisecond.
// - Short flagged only when resistance is below the fixed 500 ohm threshold.
// - Check request forces a short check even with the auto setting off.
// - Internal trigger source skips the auto check but honours the request.
// - Comparison uses only comparator settings and measurement speed.
// - Differing settings raise an alarm and block start triggers.
// - Matching settings let the start trigger begin a measurement.
// - Wider second-stage window than first stage still counts as a match.
// - First stage holds a 0.000 to 9.999 percent tolerance; each unit picks a stage.
// - With retry on, a fault restarts the measurement instead of ending it.
// - A retry reruns contact improvement and pre-measure delay, not the trigger wait.
// - Faults lasting past the retry interval stop retrying and signal done.
// - Retry interval programmable 1 to 50 ms, default 2 ms.
// - Comparison defaults off and works only when enabled on both instruments.
// - A voltage fault from probe chatter can retry and drives the error output.
package mfs_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned SHORT_DELAY_MS = 5;
  localparam int unsigned CHECK_TIME_US = 1000;
  localparam int unsigned CHECK_CYCLES = CHECK_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RETRY_MIN_MS = 1;
  localparam int unsigned RETRY_MAX_MS = 50;
  localparam int unsigned RETRY_DEF_MS = 2;
  localparam int unsigned TOL_MAX = 9999;
  localparam int unsigned SHORT_OHMS = 500;
  // APB map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_LOCAL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_ERRCODE = 8'h10;
  // CTRL fields
  localparam int unsigned CTRL_SHORT_EN = 0;
  localparam int unsigned CTRL_INT_TRIGGER = 1;
  localparam int unsigned CTRL_CMP_EN = 2;
  localparam int unsigned CTRL_SECOND = 3;
  localparam int unsigned CTRL_RETRY_EN = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_PROBE_SHORT = 8'h15;
  localparam logic [7:0] ERR_VOLT = 8'h16;
  typedef enum logic [2:0] {
    MFS_IDLE = 3'b000,
    MFS_WAIT = 3'b010,
    MFS_MEAS = 3'b001,
    MFS_POST = 3'b011,
    MFS_CHECK = 3'b110
  } mfs_state_t;
endpackage

// ===== sim/mfs_front_end.sv
// Behavioural analog front end facing the sequencer
`timescale 1ns/1ps
module mfs_front_end (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sequencer strobes
  input wire logic meas_go,
  input wire logic check_go,
  output logic meas_end,
  output logic meas_fault,
  output logic check_end,
  output logic [15:0] probe_ohms,
  // Bench control
  input wire logic fault_mode,
  input wire logic [7:0] lat,
  input wire logic [15:0] ohms_set
);
  int m_cnt;
  int c_cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_cnt <= 0;
      c_cnt <= 0;
      meas_end <= 1'b0;
      meas_fault <= 1'b0;
      check_end <= 1'b0;
      probe_ohms <= 16'h0000;
    end else begin
      // Each go pulse reruns the whole sequence, prior one dropped
      m_cnt <= meas_go ? int'(lat) + 1 : (m_cnt > 0 ? m_cnt - 1 : 0);
      meas_end <= (m_cnt == 1) && !fault_mode;
      meas_fault <= (m_cnt == 1) && fault_mode;
      c_cnt <= check_go ? int'(lat) + 1 : (c_cnt > 0 ? c_cnt - 1 : 0);
      check_end <= (c_cnt == 1);
      // Value only valid with its strobe, toggles otherwise
      probe_ohms <= (c_cnt == 1) ? ohms_set : ~probe_ohms;
    end
  end
endmodule

// ===== sim/test_meas_fault_sequencer.sv
// Self-checking bench for the measurement fault sequencer
`timescale 1ns/1ps
module test_meas_fault_sequencer;
  localparam int MSC = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0, req_n = 1'b1, fm = 1'b0;
  logic [7:0] paddr = 8'h00, lat = 8'h03, psp = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, se, done, flag_n, err, alarm, mgo, cgo, mend, mflt, cend;
  logic [15:0] ohms, oset = 16'h0000, pu = 16'h0000, pl = 16'h0000;
  logic pv = 1'b1, pen = 1'b0, p2 = 1'b0;
  int err_count = 0, tests_run = 0, cycles = 0, gos, cyc, n, at;
  int ov[4] = '{100, 499, 500, 0};
  int rm[3] = '{2, 50, 1};
  int q_ctl[4] = '{0, 0, 3, 3};
  int q_rq[4] = '{0, 1, 0, 1};
  int c_en[6] = '{1, 1, 1, 0, 1, 1};
  int c_sp[6] = '{17, 0, 17, 17, 0, 0};
  int c_up[6] = '{8, 8, 8, 8, 16, 4};
  int c_lo[6] = '{1, 1, 1, 1, 0, 2};
  int c_ok[6] = '{0, 1, 0, 1, 1, 1};
  always #12.5 pclk = ~pclk;
  mfs_top #(.SHORT_DELAY_CYC(50), .MS_CYC(MSC), .CHECK_CYC(20)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .measure_start_in(start),
    .short_check_request_n(req_n), .measure_done_out(done), .probe_short_flag_n(flag_n), .error_out(err),
    .settings_alarm(alarm), .meas_go(mgo), .check_go(cgo), .meas_end(mend), .meas_fault(mflt),
    .check_end(cend), .probe_ohms(ohms), .peer_valid(pv), .peer_enabled(pen), .peer_second(p2),
    .peer_speed(psp), .peer_upper(pu), .peer_lower(pl));
  mfs_front_end fe (.pclk(pclk), .presetn(presetn), .meas_go(mgo), .check_go(cgo), .meas_end(mend),
    .meas_fault(mflt), .check_end(cend), .probe_ohms(ohms), .fault_mode(fm), .lat(lat), .ohms_set(oset));
  task automatic results();
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Clear sticky faults; also loads the retry interval
  task automatic clear(input int ms);
    apb(mfs_pkg::ADDR_TIMING, 1'b1, {16'h0005, 8'hA5, 8'(ms)});
  endtask
  task automatic flags(input logic [7:0] code);
    apb(mfs_pkg::ADDR_ERRCODE, 1'b0, 32'h0);
    chk("error code", 32'(code), rd & 32'hFF);
    chk("short flag", 32'(code != mfs_pkg::ERR_PROBE_SHORT), 32'(flag_n));
    chk("error out", 32'(code != mfs_pkg::ERR_NONE), 32'(err));
  endtask
  task automatic meas(input logic rq);
    gos = 0;
    cyc = 0;
    @(posedge pclk);
    start <= 1'b1;
    for (int i = 0; i < 3000 && done !== 1'b1; i++) begin
      @(posedge pclk);
      if (gos > 0) cyc++;
      if (mgo === 1'b1) begin
        gos++;
        start <= 1'b0;
        req_n <= !rq;
      end
    end
    req_n <= 1'b1;
  endtask
  task automatic watch(input int win);
    n = 0;
    at = 0;
    for (int i = 1; i <= win; i++) begin
      @(posedge pclk);
      if (cgo === 1'b1) begin
        n++;
        if (at == 0) at = i;
      end
    end
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end
  initial begin
    void'($urandom(48));
    ov[3] = 501 + $urandom % 65000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(mfs_pkg::ADDR_CTRL, 1'b0, 32'h0);
    chk("ctrl reset", mfs_pkg::CTRL_RESET, rd);
    apb(8'h40, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, 32'(se));
    chk("unmapped data", 32'h0, rd);
    // Faults every attempt: default interval first, then 50 and 1
    fm <= 1'b1;
    apb(mfs_pkg::ADDR_CTRL, 1'b1, 32'h10);
    foreach (rm[i]) begin
      meas(1'b0);
      chk("retried", 32'h1, 32'(gos > 1));
      chk("retry window", 32'h1, 32'(cyc >= rm[i] * MSC - 2 && cyc <= rm[i] * MSC + 12));
      flags(mfs_pkg::ERR_VOLT);
      clear(rm[(i + 1) % 3]);
    end
    apb(mfs_pkg::ADDR_CTRL, 1'b1, 32'h0);
    meas(1'b0);
    chk("no retry", 32'h1, 32'(gos));
    clear(2);
    fm <= 1'b0;
    // Auto check, boundary and random resistances
    apb(mfs_pkg::ADDR_CTRL, 1'b1, 32'h1);
    foreach (ov[i]) begin
      oset <= 16'(ov[i]);
      meas(1'b0);
      watch(80);
      chk("auto check", 32'h1, 32'(n));
      chk("check delay", 32'h1, 32'(at >= 45 && at <= 60));
      repeat (10) @(posedge pclk);
      flags(ov[i] < 500 ? mfs_pkg::ERR_PROBE_SHORT : mfs_pkg::ERR_NONE);
      clear(2);
    end
    // Request input with auto off and with internal trigger
    oset <= 16'h000A;
    foreach (q_ctl[i]) begin
      apb(mfs_pkg::ADDR_CTRL, 1'b1, 32'(q_ctl[i]));
      meas(q_rq[i][0]);
      watch(80);
      chk("requested check", 32'(q_rq[i]), 32'(n));
      if (n > 0) chk("check after end", 32'h1, 32'(at <= 5));
      apb(mfs_pkg::ADDR_CTRL, 1'b1, 32'h0);
      repeat (30) @(posedge pclk);
      flags(n > 0 ? mfs_pkg::ERR_PROBE_SHORT : mfs_pkg::ERR_NONE);
      clear(2);
    end
    // Settings comparison gating the start trigger; out-of-range tolerance ignored
    apb(mfs_pkg::ADDR_LOCAL, 1'b1, 32'(mfs_pkg::TOL_MAX));
    apb(mfs_pkg::ADDR_LOCAL, 1'b1, 32'(mfs_pkg::TOL_MAX + 1));
    apb(mfs_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("tolerance", 32'(8'(mfs_pkg::TOL_MAX)), 32'(rd[13:6]));
    apb(mfs_pkg::ADDR_LOCAL, 1'b1, 32'h0100_0800);
    foreach (c_ok[i]) begin
      apb(mfs_pkg::ADDR_CTRL, 1'b1, (i == 5) ? 32'h0000_000C : 32'h0000_0004);
      pen <= c_en[i][0];
      p2 <= (i == 4);
      psp <= 8'(c_sp[i]);
      pu <= 16'(c_up[i]);
      pl <= 16'(c_lo[i]);
      @(posedge pclk);
      start <= 1'b1;
      gos = 0;
      repeat (12) begin
        @(posedge pclk);
        if (mgo === 1'b1) gos = 1;
      end
      start <= 1'b0;
      repeat (30) @(posedge pclk);
      chk("start accepted", 32'(c_ok[i]), 32'(gos));
      chk("alarm", 32'(c_ok[i] == 0), 32'(alarm));
    end
    results();
  end
endmodule
